// file: rtl/mh_pkg.sv
// shared constants, types and serial engine steps for the host serial ports
`default_nettype none
package mh_pkg;
  localparam int CLK_MHZ      = 100;
  localparam int CLK_HZ       = CLK_MHZ * 1000000;
  localparam int BAUD_FAST    = 921600;
  localparam int BAUD_CONSOLE = 115200;
  localparam int NPORTS       = 3;
  localparam int DATA_BITS    = 8;
  localparam int STOP_BITS    = 1;
  localparam int DW           = 12;
  // divisors round down: at most a few tenths of a percent fast, well inside tolerance
  localparam logic [DW-1:0] DIV_FAST    = DW'(CLK_HZ / BAUD_FAST);
  localparam logic [DW-1:0] DIV_CONSOLE = DW'(CLK_HZ / BAUD_CONSOLE);
  localparam logic [NPORTS-1:0][DW-1:0] PORT_DIV = {DIV_FAST, DIV_CONSOLE, DIV_FAST};
  localparam logic [3:0] FRAME_BITS = 4'(1 + DATA_BITS + STOP_BITS);
  localparam logic [3:0] STOP_POS   = 4'(DATA_BITS + 1);
  // width of the low pulse on the ring line
  localparam int         RING_LOW_NS  = 1000;
  localparam logic [7:0] RING_LOW_CYC = 8'((RING_LOW_NS * CLK_MHZ + 999) / 1000);

  typedef enum logic [1:0] {
    MH_ROLE_CMD     = 2'h0,
    MH_ROLE_CONSOLE = 2'h1,
    MH_ROLE_DEBUG   = 2'h3
  } mh_role_e;
  localparam logic [NPORTS-1:0][1:0] ROLE_RST = {MH_ROLE_DEBUG, MH_ROLE_CONSOLE, MH_ROLE_CMD};
  localparam logic [NPORTS-1:0] FLOW_RST = 3'h5;
  localparam int                FLOW_FIXED_PORT = 2;

  typedef enum logic [1:0] {
    MH_ST_BOOT   = 2'h0,
    MH_ST_ACTIVE = 2'h1,
    MH_ST_LOWPWR = 2'h3
  } mh_state_e;

  typedef struct packed {
    logic          busy;
    logic [9:0]    sh;
    logic [3:0]    bits;
    logic [DW-1:0] cnt;
  } mh_tx_s;

  typedef struct packed {
    logic          busy;
    logic [7:0]    sh;
    logic [3:0]    bits;
    logic [DW-1:0] cnt;
    logic          done;
    logic          ferr;
  } mh_rx_s;

  // start a frame: start bit, lsb first data, stop bit
  function automatic mh_tx_s mh_tx_load(input logic [7:0] d, input logic [DW-1:0] div);
    mh_tx_s t;
    t.busy = 1'b1;
    t.sh   = {1'b1, d, 1'b0};
    t.bits = FRAME_BITS;
    t.cnt  = div - DW'(1);
    return t;
  endfunction

  function automatic mh_tx_s mh_tx_step(input mh_tx_s s, input logic [DW-1:0] div);
    mh_tx_s t;
    t = s;
    if (s.busy) begin
      if (s.cnt == '0) begin
        t.sh   = {1'b1, s.sh[9:1]};
        t.bits = s.bits - 4'h1;
        t.cnt  = div - DW'(1);
        t.busy = (s.bits != 4'h1);
      end else begin
        t.cnt = s.cnt - DW'(1);
      end
    end
    return t;
  endfunction

  // samples mid bit; a start bit that is high at mid point is a glitch
  function automatic mh_rx_s mh_rx_step(input mh_rx_s s, input logic line,
                                        input logic [DW-1:0] div);
    mh_rx_s t;
    t      = s;
    t.done = 1'b0;
    t.ferr = 1'b0;
    if (!s.busy) begin
      if (!line) begin
        t.busy = 1'b1;
        t.bits = 4'h0;
        t.cnt  = div >> 1;
      end
    end else if (s.cnt != '0) begin
      t.cnt = s.cnt - DW'(1);
    end else begin
      t.cnt  = div - DW'(1);
      t.bits = s.bits + 4'h1;
      if (s.bits == 4'h0) begin
        t.busy = !line;
      end else if (s.bits == STOP_POS) begin
        t.busy = 1'b0;
        t.done = line;
        t.ferr = !line;
      end else begin
        t.sh = {line, s.sh[7:1]};
      end
    end
    return t;
  endfunction
endpackage
`default_nettype wire

// file: rtl/mh_link_if.sv
// pins between the modem serial ports and the host
`timescale 1ns/1ns
`default_nettype none
interface mh_link_if;
  logic first_port_rx_out;
  logic first_port_tx_in;
  logic first_port_request_wake_in_n;
  logic first_port_clear_out_n;
  logic second_port_rx_out;
  logic second_port_tx_in;
  logic second_port_request_in_n;
  logic second_port_clear_out_n;
  logic third_port_rx_out;
  logic third_port_tx_in;
  logic third_port_request_in_n;
  logic third_port_clear_out_n;
  logic ring_indicator_out;
  logic ring_indicator_oe_n;
  logic ring_level;
  logic power_saving_status_out;
  logic boot_source_strap;

  // host side pull-up keeps the ring line high while it floats
  assign ring_level = ring_indicator_oe_n ? 1'b1 : ring_indicator_out;

  modport dev (
    output first_port_rx_out, first_port_clear_out_n, second_port_rx_out,
    output second_port_clear_out_n, third_port_rx_out, third_port_clear_out_n,
    output ring_indicator_out, ring_indicator_oe_n, power_saving_status_out,
    input  first_port_tx_in, first_port_request_wake_in_n, second_port_tx_in,
    input  second_port_request_in_n, third_port_tx_in, third_port_request_in_n,
    input  boot_source_strap
  );
  modport host (
    input  first_port_rx_out, first_port_clear_out_n, second_port_rx_out,
    input  second_port_clear_out_n, third_port_rx_out, third_port_clear_out_n,
    input  ring_level, power_saving_status_out,
    output first_port_tx_in, first_port_request_wake_in_n, second_port_tx_in,
    output second_port_request_in_n, third_port_tx_in, third_port_request_in_n,
    output boot_source_strap
  );
endinterface
`default_nettype wire

// file: rtl/mh_dev_end.sv
// modem end of the three host serial ports, with wake and boot handling
//
// Function
// - three independent serial ports, request/clear flow on first and third
// - software selects each port role, legal set
// - first port command role, 921600 8N1, flow on
// - second port console, 115200 8N1, no flow
// - third port debug role, 921600 8N1, flow always
// - host honours first port flow during boot
// - modem is DCE: drives rx, clear lines
// - flowless host ties lines low, checks status
// - first port request input wakes low power
// - ring low wakes host, send without waiting
// - host reads promptly after ring falls
// - ring line floats while modem suspended
// - early bytes after wake may be dropped
// - second port activity wakes only when enabled
// - third port activity never wakes modem
// - second port serial by default, flow reserved
// - strap low selects recovery over third port
// - status high active, low in low power
`timescale 1ns/1ns
`default_nettype none
module mh_dev_end
  import mh_pkg::*;
(
  input  wire logic                         i_core_clk,
  input  wire logic                         i_rst_n,
  mh_link_if.dev                            lk,
  input  wire logic [NPORTS-1:0][7:0]       i_tx_data,
  input  wire logic [NPORTS-1:0]            i_tx_valid,
  output logic      [NPORTS-1:0]            o_tx_ready,
  output logic      [NPORTS-1:0][7:0]       o_rx_data,
  output logic      [NPORTS-1:0]            o_rx_valid,
  output logic      [NPORTS-1:0]            o_rx_drop,
  output logic      [NPORTS-1:0]            o_rx_ferr,
  input  wire logic [NPORTS-1:0]            i_rx_ready,
  input  wire logic                         i_role_wr,
  input  wire logic [1:0]                   i_role_port,
  input  wire logic [1:0]                   i_role_val,
  output logic      [NPORTS-1:0][1:0]       o_role,
  input  wire logic                         i_cfg_wr,
  input  wire logic                         i_cfg_flow0,
  input  wire logic                         i_cfg_p1_wake,
  output logic      [NPORTS-1:0]            o_flow,
  input  wire logic                         i_lp_enter,
  input  wire logic                         i_ring_req,
  input  wire logic                         i_suspend,
  output logic                              o_wake,
  output logic                              o_recovery_mode,
  output logic                              o_active
);

  // the whole state of this end
  typedef struct packed {
    mh_state_e                  st;
    logic                       recov;
    logic [NPORTS-1:0][1:0]     role;
    logic [NPORTS-1:0]          flow;
    logic                       p1_wake;
    mh_tx_s [NPORTS-1:0]        tx;
    mh_rx_s [NPORTS-1:0]        rx;
    logic [NPORTS-1:0]          line;
    logic [NPORTS-1:0]          clear_n;
    logic [NPORTS-1:0]          tx_ready;
    logic [NPORTS-1:0][7:0]     rx_data;
    logic [NPORTS-1:0]          rx_valid;
    logic [NPORTS-1:0]          rx_drop;
    logic [NPORTS-1:0]          rx_ferr;
    logic                       ring_n;
    logic                       ring_oe_n;
    logic [7:0]                 ring_cnt;
    logic                       ps;
    logic                       wake;
  } mh_dev_s;

  mh_dev_s           s_r;
  mh_dev_s           s_nxt;
  logic [NPORTS-1:0] req_n;
  logic [NPORTS-1:0] tx_in;

  // gather the link inputs into vectors, port 0 in bit 0
  assign req_n = {lk.third_port_request_in_n, lk.second_port_request_in_n,
                  lk.first_port_request_wake_in_n};
  assign tx_in = {lk.third_port_tx_in, lk.second_port_tx_in, lk.first_port_tx_in};

  always_comb begin
    logic any_busy;
    any_busy         = 1'b0;
    s_nxt            = s_r;
    s_nxt.wake       = 1'b0;
    s_nxt.rx_valid   = '0;
    s_nxt.rx_drop    = '0;
    s_nxt.rx_ferr    = '0;
    for (int i = 0; i < NPORTS; i++) begin
      any_busy = any_busy | s_r.tx[i].busy;
    end

    // boot, active and low power sequencing
    case (s_r.st)
      MH_ST_BOOT: begin
        s_nxt.recov = !lk.boot_source_strap;
        s_nxt.st  = MH_ST_ACTIVE;
      end
      MH_ST_ACTIVE: begin
        // never sleep with a frame half sent
        if (i_lp_enter && !any_busy) begin
          s_nxt.st = MH_ST_LOWPWR;
        end
      end
      MH_ST_LOWPWR: begin
        // third port line is deliberately not a wake source
        if (!req_n[0] || (s_r.p1_wake && !tx_in[1]) || i_ring_req) begin
          s_nxt.st   = MH_ST_ACTIVE;
          s_nxt.wake = 1'b1;
        end
      end
      default: begin
        s_nxt.st = MH_ST_BOOT;
      end
    endcase

    // role writes outside the legal set for a port are ignored
    if (i_role_wr) begin
      if (i_role_port == 2'h2) begin
        if (i_role_val == MH_ROLE_CMD || i_role_val == MH_ROLE_DEBUG) begin
          s_nxt.role[2] = i_role_val;
        end
      end else if (i_role_port < 2'h2) begin
        if (i_role_val == MH_ROLE_CMD || i_role_val == MH_ROLE_CONSOLE) begin
          s_nxt.role[i_role_port] = i_role_val;
        end
      end
    end
    // recovery pins the third port to the debug role
    if (s_nxt.recov) begin
      s_nxt.role[2] = MH_ROLE_DEBUG;
    end

    // flow configuration: second port flow pins stay reserved
    if (i_cfg_wr) begin
      s_nxt.flow[0] = i_cfg_flow0;
      s_nxt.p1_wake = i_cfg_p1_wake;
    end
    s_nxt.flow[1]               = 1'b0;
    s_nxt.flow[FLOW_FIXED_PORT] = 1'b1;

    // ring pulse toward the host; floats in suspend
    if (i_ring_req) begin
      s_nxt.ring_n   = 1'b0;
      s_nxt.ring_cnt = RING_LOW_CYC - 8'h01;
    end else if (!s_r.ring_n) begin
      if (s_r.ring_cnt == 8'h00) begin
        s_nxt.ring_n = 1'b1;
      end else begin
        s_nxt.ring_cnt = s_r.ring_cnt - 8'h01;
      end
    end
    s_nxt.ring_oe_n = i_suspend;
    s_nxt.ps        = (s_nxt.st != MH_ST_LOWPWR);

    // per port serial engines
    for (int i = 0; i < NPORTS; i++) begin
      s_nxt.tx[i] = mh_tx_step(s_r.tx[i], PORT_DIV[i]);
      // sends as soon as data is offered, no host acknowledgement
      if (s_r.tx_ready[i] && i_tx_valid[i]) begin
        s_nxt.tx[i] = mh_tx_load(i_tx_data[i], PORT_DIV[i]);
      end
      s_nxt.line[i] = !s_nxt.tx[i].busy | s_nxt.tx[i].sh[0];
      s_nxt.rx[i]   = mh_rx_step(s_r.rx[i], tx_in[i], PORT_DIV[i]);
      if (s_nxt.rx[i].done) begin
        // a byte that nobody can take is dropped and flagged
        if (s_r.st == MH_ST_ACTIVE && i_rx_ready[i]) begin
          s_nxt.rx_valid[i] = 1'b1;
          s_nxt.rx_data[i]  = s_nxt.rx[i].sh;
        end else begin
          s_nxt.rx_drop[i] = 1'b1;
        end
      end
      s_nxt.rx_ferr[i] = s_nxt.rx[i].ferr;
      // without flow the clear line reads clear, as a grounded host expects
      s_nxt.clear_n[i] = s_nxt.flow[i] &
                         !(s_nxt.st == MH_ST_ACTIVE && i_rx_ready[i]);
      // host request gates sending; it lags one cycle through this flop
      s_nxt.tx_ready[i] = !s_nxt.tx[i].busy && s_nxt.st == MH_ST_ACTIVE &&
                          (!s_nxt.flow[i] || !req_n[i]);
    end
  end

  // single state register, synchronous reset to the documented defaults
  always_ff @(posedge i_core_clk) begin
    if (!i_rst_n) begin
      s_r           <= '0;
      s_r.st        <= MH_ST_BOOT;
      s_r.role      <= ROLE_RST;
      s_r.flow      <= FLOW_RST;
      s_r.line      <= '1;
      s_r.clear_n   <= FLOW_RST;
      s_r.ring_n    <= 1'b1;
      s_r.ps        <= 1'b1;
    end else begin
      s_r <= s_nxt;
    end
  end

  // link pins, all straight from the state register
  assign lk.first_port_rx_out       = s_r.line[0];
  assign lk.second_port_rx_out      = s_r.line[1];
  assign lk.third_port_rx_out       = s_r.line[2];
  assign lk.first_port_clear_out_n  = s_r.clear_n[0];
  assign lk.second_port_clear_out_n = s_r.clear_n[1];
  assign lk.third_port_clear_out_n  = s_r.clear_n[2];
  assign lk.ring_indicator_out      = s_r.ring_n;
  assign lk.ring_indicator_oe_n     = s_r.ring_oe_n;
  assign lk.power_saving_status_out = s_r.ps;

  // user side outputs
  assign o_tx_ready = s_r.tx_ready;
  assign o_rx_data  = s_r.rx_data;
  assign o_rx_valid = s_r.rx_valid;
  assign o_rx_drop  = s_r.rx_drop;
  assign o_rx_ferr  = s_r.rx_ferr;
  assign o_role     = s_r.role;
  assign o_flow     = s_r.flow;
  assign o_wake     = s_r.wake;
  assign o_recovery_mode = s_r.recov;
  assign o_active   = s_r.ps;
endmodule
`default_nettype wire

// file: rtl/mh_host_end.sv
// host end of the three modem serial ports
`timescale 1ns/1ns
`default_nettype none
module mh_host_end
  import mh_pkg::*;
(
  input  wire logic                   i_core_clk,
  input  wire logic                   i_rst_n,
  mh_link_if.host                     lk,
  input  wire logic [NPORTS-1:0][7:0] i_tx_data,
  input  wire logic [NPORTS-1:0]      i_tx_valid,
  output logic      [NPORTS-1:0]      o_tx_ready,
  output logic      [NPORTS-1:0][7:0] o_rx_data,
  output logic      [NPORTS-1:0]      o_rx_valid,
  output logic      [NPORTS-1:0]      o_rx_ferr,
  input  wire logic [NPORTS-1:0]      i_rx_ready,
  input  wire logic [1:0]             i_flow_en,
  input  wire logic                   i_wake_req,
  input  wire logic                   i_recovery,
  output logic                        o_ring_seen
);

  typedef struct packed {
    mh_tx_s [NPORTS-1:0]    tx;
    mh_rx_s [NPORTS-1:0]    rx;
    logic [NPORTS-1:0]      line;
    logic [NPORTS-1:0]      req_n;
    logic [NPORTS-1:0]      tx_ready;
    logic [NPORTS-1:0][7:0] rx_data;
    logic [NPORTS-1:0]      rx_valid;
    logic [NPORTS-1:0]      rx_ferr;
    logic                   ring_prev;
    logic                   ring_seen;
    logic                   strap;
  } mh_host_s;

  mh_host_s          s_r;
  mh_host_s          s_nxt;
  logic [NPORTS-1:0] flow;
  logic [NPORTS-1:0] clear_n;
  logic [NPORTS-1:0] rx_in;

  assign flow    = {1'b1, i_flow_en};
  assign clear_n = {lk.third_port_clear_out_n, lk.second_port_clear_out_n,
                    lk.first_port_clear_out_n};
  assign rx_in   = {lk.third_port_rx_out, lk.second_port_rx_out, lk.first_port_rx_out};

  always_comb begin
    s_nxt          = s_r;
    s_nxt.rx_valid = '0;
    // catch the falling ring edge so the reader starts at once
    s_nxt.ring_prev = lk.ring_level;
    s_nxt.ring_seen = s_r.ring_prev & !lk.ring_level;
    s_nxt.strap     = !i_recovery;
    for (int i = 0; i < NPORTS; i++) begin
      s_nxt.tx[i] = mh_tx_step(s_r.tx[i], PORT_DIV[i]);
      if (s_r.tx_ready[i] && i_tx_valid[i]) begin
        s_nxt.tx[i] = mh_tx_load(i_tx_data[i], PORT_DIV[i]);
      end
      s_nxt.line[i] = !s_nxt.tx[i].busy | s_nxt.tx[i].sh[0];
      s_nxt.rx[i]   = mh_rx_step(s_r.rx[i], rx_in[i], PORT_DIV[i]);
      if (s_nxt.rx[i].done) begin
        s_nxt.rx_valid[i] = 1'b1;
        s_nxt.rx_data[i]  = s_nxt.rx[i].sh;
      end
      s_nxt.rx_ferr[i] = s_nxt.rx[i].ferr;
      // flowless ports hold the request line low
      s_nxt.req_n[i] = flow[i] & !i_rx_ready[i];
      // without flow, wait for the modem to report itself awake
      s_nxt.tx_ready[i] = !s_nxt.tx[i].busy &&
                          (flow[i] ? !clear_n[i] : lk.power_saving_status_out);
    end
    if (i_wake_req) begin
      s_nxt.req_n[0] = 1'b0;
    end
  end

  always_ff @(posedge i_core_clk) begin
    if (!i_rst_n) begin
      s_r           <= '0;
      s_r.line      <= '1;
      s_r.req_n     <= '1;
      s_r.ring_prev <= 1'b1;
      // strap follows the request through reset: the modem samples it right after
      s_r.strap     <= !i_recovery;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign lk.first_port_tx_in             = s_r.line[0];
  assign lk.second_port_tx_in            = s_r.line[1];
  assign lk.third_port_tx_in             = s_r.line[2];
  assign lk.first_port_request_wake_in_n = s_r.req_n[0];
  assign lk.second_port_request_in_n     = s_r.req_n[1];
  assign lk.third_port_request_in_n      = s_r.req_n[2];
  assign lk.boot_source_strap            = s_r.strap;
  assign o_tx_ready  = s_r.tx_ready;
  assign o_rx_data   = s_r.rx_data;
  assign o_rx_valid  = s_r.rx_valid;
  assign o_rx_ferr   = s_r.rx_ferr;
  assign o_ring_seen = s_r.ring_seen;
endmodule
`default_nettype wire

// file: tb/mh_monitor.sv
// assertion checker on the pins between the modem and host ends
`timescale 1ns/1ns
`default_nettype none
module mh_monitor
  import mh_pkg::*;
(
  input  wire logic i_core_clk,
  input  wire logic i_rst_n,
  input  wire logic first_port_rx_out,
  input  wire logic first_port_request_wake_in_n,
  input  wire logic first_port_clear_out_n,
  input  wire logic second_port_tx_in,
  input  wire logic second_port_clear_out_n,
  input  wire logic third_port_rx_out,
  input  wire logic third_port_request_in_n,
  input  wire logic third_port_clear_out_n,
  input  wire logic ring_indicator_out,
  input  wire logic power_saving_status_out
);
  logic [7:0] low_cnt_r;
  logic [7:0] low_cnt_nxt;

  // length of the current low stretch on the ring line
  always_comb low_cnt_nxt = ring_indicator_out ? 8'h00 : low_cnt_r + 8'h01;
  always_ff @(posedge i_core_clk) begin
    low_cnt_r <= i_rst_n ? low_cnt_nxt : 8'h00;
  end

  default clocking @(posedge i_core_clk); endclocking
  default disable iff (!i_rst_n);

  // first edge after release still shows the reset levels
  a_reset_lines: assert property ($rose(i_rst_n) |->
    first_port_clear_out_n && !second_port_clear_out_n && third_port_clear_out_n &&
    first_port_rx_out && third_port_rx_out && ring_indicator_out && power_saving_status_out)
    else $error("pin levels wrong after reset");
  a_console_no_flow: assert property (!second_port_clear_out_n)
    else $error("second port clear line left the go level");
  // a host that has refused for three cycles gets no new frame
  a_third_gated: assert property ($fell(third_port_rx_out) |->
    !($past(third_port_request_in_n) && $past(third_port_request_in_n, 2) &&
      $past(third_port_request_in_n, 3)))
    else $error("third port frame started against host flow");
  a_ring_width: assert property ($rose(ring_indicator_out) |->
    low_cnt_r == RING_LOW_CYC)
    else $error("ring pulse width wrong");
  a_ring_wakes: assert property ($fell(ring_indicator_out) |-> power_saving_status_out)
    else $error("ring fell without modem active");
  a_wake_cause: assert property ($rose(power_saving_status_out) |->
    !ring_indicator_out || !$past(first_port_request_wake_in_n) ||
    !$past(first_port_request_wake_in_n, 2) || !$past(second_port_tx_in) ||
    !$past(second_port_tx_in, 2))
    else $error("modem woke without a wake source");
  a_status_wake: assert property (!power_saving_status_out &&
    !first_port_request_wake_in_n |-> ##[1:3] power_saving_status_out)
    else $error("request line did not wake the modem");
  a_start_held: assert property ($fell(first_port_rx_out) |->
    !first_port_rx_out[*8])
    else $error("start bit too short");

  c_ring: cover property ($fell(ring_indicator_out));
  c_low_power: cover property ($fell(power_saving_status_out));
  c_third_frame: cover property ($fell(third_port_rx_out));
endmodule
`default_nettype wire

// file: tb/modem_host_uart_ports_tb_top.sv
// self-checking bench joining the modem and host ends of the serial ports
`timescale 1ns/1ns
`default_nettype none
module modem_host_uart_ports_tb_top import mh_pkg::*;;
  logic [NPORTS-1:0][7:0] d_txd, d_rxd, h_txd, h_rxd;
  logic [NPORTS-1:0]      d_txv, d_txr, d_rxv, d_drop, d_ferr, d_rxr, flow;
  logic [NPORTS-1:0]      h_txv, h_txr, h_rxv, h_ferr, h_rxr;
  logic [NPORTS-1:0][1:0] role;
  logic [1:0]             role_port, role_val, h_flow;
  logic                   clk, rst_n, role_wr, cfg_wr, flow0, p1_wake, lp, ring_req;
  logic                   susp, wake, recov, active, h_wake, h_rec, h_ring;
  int                     err_total, samples_checked, rings, wakes, ferrs;
  int                     cyc = 0;
  // role table entries: port, value written, value expected after
  logic [0:8][5:0]        rt = {6'h05, 6'h0d, 6'h00, 6'h10, 6'h1c, 6'h15, 6'h27, 6'h20, 6'h2f};

  mh_link_if lk ();
  wire logic [5:0] pins = {lk.third_port_tx_in, lk.second_port_tx_in, lk.first_port_tx_in,
                           lk.third_port_rx_out, lk.second_port_rx_out, lk.first_port_rx_out};

  mh_dev_end u_mh_dev_end (.i_core_clk(clk), .i_rst_n(rst_n), .lk(lk.dev), .i_tx_data(d_txd),
    .i_tx_valid(d_txv), .o_tx_ready(d_txr), .o_rx_data(d_rxd), .o_rx_valid(d_rxv),
    .o_rx_drop(d_drop), .o_rx_ferr(d_ferr), .i_rx_ready(d_rxr), .i_role_wr(role_wr),
    .i_role_port(role_port), .i_role_val(role_val), .o_role(role), .i_cfg_wr(cfg_wr),
    .i_cfg_flow0(flow0), .i_cfg_p1_wake(p1_wake), .o_flow(flow), .i_lp_enter(lp),
    .i_ring_req(ring_req), .i_suspend(susp), .o_wake(wake), .o_recovery_mode(recov),
    .o_active(active));
  mh_host_end u_mh_host_end (.i_core_clk(clk), .i_rst_n(rst_n), .lk(lk.host),
    .i_tx_data(h_txd), .i_tx_valid(h_txv), .o_tx_ready(h_txr), .o_rx_data(h_rxd),
    .o_rx_valid(h_rxv), .o_rx_ferr(h_ferr), .i_rx_ready(h_rxr), .i_flow_en(h_flow),
    .i_wake_req(h_wake), .i_recovery(h_rec), .o_ring_seen(h_ring));
  mh_monitor mon (.i_core_clk(clk), .i_rst_n(rst_n),
    .first_port_rx_out(lk.first_port_rx_out),
    .first_port_request_wake_in_n(lk.first_port_request_wake_in_n),
    .first_port_clear_out_n(lk.first_port_clear_out_n),
    .second_port_tx_in(lk.second_port_tx_in),
    .second_port_clear_out_n(lk.second_port_clear_out_n),
    .third_port_rx_out(lk.third_port_rx_out),
    .third_port_request_in_n(lk.third_port_request_in_n),
    .third_port_clear_out_n(lk.third_port_clear_out_n),
    .ring_indicator_out(lk.ring_indicator_out),
    .power_saving_status_out(lk.power_saving_status_out));

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  task automatic give_verdict();
    $display("compared %0d mismatched %0d", samples_checked, err_total);
    if (err_total == 0 && samples_checked > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  // about twice the expected run; second port frames dominate
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (h_ring) rings <= rings + 1;
    if (wake) wakes <= wakes + 1;
    if (|{d_ferr, h_ferr}) ferrs <= ferrs + 1;
    if (cyc == 80000) begin
      err_total++;
      give_verdict();
    end
  end

  task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
    samples_checked++;
    if (got !== exp) begin
      err_total++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge clk);
  endtask

  task automatic do_reset();
    rst_n <= 1'b0;
    tick(12);
    rst_n <= 1'b1;
    tick(3);
  endtask

  // one byte on port p, dir 1 host to modem; k set when the modem must drop it
  task automatic xfer(input logic dir, input int p, input logic [7:0] b, input logic k);
    int n;
    logic [9:0] f;
    logic [1:0] g;
    n = 0;
    f = 10'h000;
    g = 2'h0;
    if (dir) begin
      h_txd[p] <= b;
      h_txv[p] <= 1'b1;
    end else begin
      d_txd[p] <= b;
      d_txv[p] <= 1'b1;
    end
    do begin
      @(posedge clk);
      n++;
    end while (!(dir ? h_txr[p] : d_txr[p]) && n < 20000);
    h_txv[p] <= 1'b0;
    d_txv[p] <= 1'b0;
    fork
      begin // wire sampled at the middle of every bit
        tick(1 + int'(PORT_DIV[p]) / 2);
        for (int i = 0; i < 10; i++) begin
          f[i] = pins[3 * dir + p];
          tick(int'(PORT_DIV[p]));
        end
      end
      begin
        n = 0;
        do begin
          @(posedge clk);
          n++;
        end while (!(dir ? (d_rxv[p] | d_drop[p]) : h_rxv[p]) && n < 20000);
        g = dir ? {d_drop[p], d_rxv[p]} : {1'b0, h_rxv[p]};
      end
    join
    chk("frame data", b, f[8:1]);
    chk("frame ends", 8'h02, {6'h00, f[9], f[0]});
    chk("rx kind", k ? 8'h02 : 8'h01, {6'h00, g});
    if (!k) chk("rx data", b, dir ? d_rxd[p] : h_rxd[p]);
  endtask

  task automatic role_set(input logic [1:0] p, input logic [1:0] v, input logic [1:0] e);
    role_wr <= 1'b1;
    role_port <= p;
    role_val <= v;
    tick(1);
    role_wr <= 1'b0;
    tick(2);
    chk("role", {6'h00, e}, {6'h00, role[p]});
  endtask

  task automatic cfg(input logic f);
    flow0 <= f;
    cfg_wr <= 1'b1;
    tick(1);
    cfg_wr <= 1'b0;
    tick(3);
  endtask

  initial begin
    {d_txd, h_txd, d_txv, h_txv, role_wr, cfg_wr, lp, ring_req, susp, h_wake, h_rec} = '0;
    {role_port, role_val, p1_wake, err_total, samples_checked, rings, wakes, ferrs} = '0;
    {d_rxr, h_rxr, flow0, h_flow} = {3'h7, 3'h7, 1'b1, 2'h1};
    rst_n = 1'b0;
    do_reset();
    chk("roles", 8'h34, {2'h0, role});
    chk("flow", 8'h05, {5'h00, flow});
    chk("mode", 8'h03, {5'h00, recov, active, lk.power_saving_status_out});
    chk("clear pins", 8'h00, {5'h00, lk.third_port_clear_out_n,
      lk.second_port_clear_out_n, lk.first_port_clear_out_n});
    for (int d = 0; d < 2; d++) begin
      for (int p = 0; p < NPORTS; p++) begin
        xfer(d[0], p, 8'h5a ^ 8'(p * 37 + d), 1'b0);
      end
    end
    for (int i = 0; i < 9; i++) begin
      role_set(rt[i][5:4], rt[i][3:2], rt[i][1:0]);
    end
    // flow off first: its clear line must read go whatever the user says
    d_rxr[0] <= 1'b0;
    cfg(1'b0);
    chk("flow off", 8'h04, {5'h00, flow});
    chk("clear off", 8'h00, {7'h00, lk.first_port_clear_out_n});
    cfg(1'b1);
    chk("clear on", 8'h01, {7'h00, lk.first_port_clear_out_n});
    d_rxr[0] <= 1'b1;
    // third port stalled by the receiving side in each direction
    for (int d = 0; d < 2; d++) begin
      d_rxr[2] <= !d[0];
      h_rxr[2] <= d[0];
      tick(4);
      fork
        xfer(d[0], 2, 8'hc3, 1'b0);
        begin
          tick(200);
          chk("stalled line", 8'h01, {7'h00, pins[3 * d + 2]});
          d_rxr[2] <= 1'b1;
          h_rxr[2] <= 1'b1;
        end
      join
    end
    d_rxr[1] <= 1'b0;
    xfer(1'b1, 1, 8'h96, 1'b1);
    d_rxr[1] <= 1'b1;
    // host not ready keeps the wake request line idle
    h_rxr[0] <= 1'b0;
    for (int w = 0; w < 2; w++) begin
      tick(3);
      lp <= 1'b1;
      tick(1);
      lp <= 1'b0;
      tick(3);
      chk("low power", 8'h00, {6'h00, active, lk.power_saving_status_out});
      h_wake <= !w[0];
      ring_req <= w[0];
      tick(1);
      ring_req <= 1'b0;
      tick(50);
      chk("woken", {5'h00, w[0], 2'h3},
        {5'h00, !lk.ring_level, active, lk.power_saving_status_out});
      h_wake <= 1'b0;
    end
    h_rxr[0] <= 1'b1;
    xfer(1'b0, 0, 8'h3c, 1'b0);
    // ring while suspended must not reach the host
    susp <= 1'b1;
    ring_req <= 1'b1;
    tick(1);
    ring_req <= 1'b0;
    tick(20);
    chk("ring float", 8'h03, {6'h00, lk.ring_indicator_oe_n, lk.ring_level});
    tick(95);
    susp <= 1'b0;
    tick(5);
    chk("rings seen", 8'h01, 8'(rings));
    chk("wakes", 8'h02, 8'(wakes));
    h_rec <= 1'b1;
    do_reset();
    chk("recovery", 8'h07, {5'h00, recov, active, lk.power_saving_status_out});
    role_set(2'h2, 2'h0, 2'h3);
    xfer(1'b1, 2, 8'h81, 1'b0);
    h_rec <= 1'b0;
    do_reset();
    chk("flash boot", 8'h03, {5'h00, recov, active, lk.power_saving_status_out});
    chk("frame errors", 8'h00, 8'(ferrs));
    give_verdict();
  end
endmodule
`default_nettype wire
